// [rtl/vcc_regs.vh]
// Contract
// - two identical comparators; only zero resets system
// - clock-synchronous latched output plus raw asynchronous output
// - result polled, interrupts, wakes oscillator, drives pin
// - disabled comparator drives its output pin low
// - control bit 7 switches comparator on/off
// - control bit 6 reads current comparator result
// - sticky rise flag bit 5, fall flag bit 4
// - interrupt on rising, falling or both edges
// - enabled and output low wakes the oscillator
// - control bits 3-2 select positive hysteresis
// - control bits 1-0 select negative hysteresis
// - select bits 7-4 choose negative input pin
// - select bits 3-0 choose positive input pin
// - mode register selects response time and power
// - mode bit 5 rise, bit 4 fall interrupt enables
// - mode bits 1-0 speed, reset value 10
// - second control register same layout, resets zero
`ifndef VCC_REGS_VH
`define VCC_REGS_VH

// ==========================================================
// register addresses
`define VCC_ADDR_CTL1     8'h9a
`define VCC_ADDR_CTL0     8'h9b
`define VCC_ADDR_MODE1    8'h9c
`define VCC_ADDR_MODE0    8'h9d
`define VCC_ADDR_SEL1     8'h9e
`define VCC_ADDR_SEL0     8'h9f

// ==========================================================
// field positions
`define VCC_CTL_EN        7
`define VCC_CTL_OUT       6
`define VCC_CTL_RISE      5
`define VCC_CTL_FALL      4
`define VCC_CTL_HYP_HI    3
`define VCC_CTL_HYP_LO    2
`define VCC_CTL_HYN_HI    1
`define VCC_CTL_HYN_LO    0
`define VCC_MODE_RIE      5
`define VCC_MODE_FIE      4
`define VCC_MODE_MD_HI    1
`define VCC_MODE_MD_LO    0
`define VCC_SEL_NEG_HI    7
`define VCC_SEL_NEG_LO    4
`define VCC_SEL_POS_HI    3
`define VCC_SEL_POS_LO    0

// ==========================================================
// reset values
`define VCC_RST_CTL       8'h00
`define VCC_RST_MODE      8'h02
`define VCC_RST_SEL       8'hff
`define VCC_RST_SPEED     2'h2
`define VCC_RST_HYST      2'h0

`endif

// [rtl/vcc_edge.v]
`timescale 1ns/1ps
// ==========================================================
// synchroniser and edge detector for one comparator
module vcc_edge (
    // clock and reset
    input  wire clk_sys,
    input  wire rst,
    input  wire ce,
    // control
    input  wire enable,
    // raw comparator decision
    input  wire analog_in,
    // results
    output reg  result_q,
    output reg  rise_q,
    output reg  fall_q
);
    reg meta_q;
    reg sync_q;

    // meta_q feeds only sync_q
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_q   <= 1'b0;
            sync_q   <= 1'b0;
            result_q <= 1'b0;
            rise_q   <= 1'b0;
            fall_q   <= 1'b0;
        end else if (ce) begin
            meta_q   <= analog_in;
            sync_q   <= meta_q;
            // disabled comparator reads and drives low
            result_q <= enable & sync_q;
            rise_q   <= enable & sync_q & ~result_q;
            fall_q   <= result_q & ~(enable & sync_q);
        end
    end
endmodule // vcc_edge

// [rtl/vcc_top.v]
`timescale 1ns/1ps
`include "vcc_regs.vh"
// ==========================================================
// control and status logic of two voltage comparators
module vcc_top (
    // clock, reset, clock enable
    input  wire       clk_sys,
    input  wire       rst,
    input  wire       ce,
    // special-function register port
    input  wire [7:0] sfr_addr,
    input  wire       sfr_wr,
    input  wire [7:0] sfr_wdata,
    input  wire       sfr_rd,
    output reg  [7:0] sfr_rdata_q,
    // analog comparator decisions
    input  wire       cmp0_analog_in,
    input  wire       cmp1_analog_in,
    // comparator 0 analog controls
    output reg        cmp0_enable_bit,
    output reg  [1:0] cmp0_pos_hysteresis,
    output reg  [1:0] cmp0_neg_hysteresis,
    output reg  [3:0] cmp0_pos_input_sel,
    output reg  [3:0] cmp0_neg_input_sel,
    output reg  [1:0] cmp0_speed_mode,
    // comparator 1 analog controls
    output reg        cmp1_enable_bit,
    output reg  [1:0] cmp1_pos_hysteresis,
    output reg  [1:0] cmp1_neg_hysteresis,
    output reg  [3:0] cmp1_pos_input_sel,
    output reg  [3:0] cmp1_neg_input_sel,
    output reg  [1:0] cmp1_speed_mode,
    // comparator outputs
    output wire       cmp0_raw_out,
    output wire       cmp1_raw_out,
    output wire       cmp0_latched_out,
    output wire       cmp1_latched_out,
    // requests
    output reg        cmp0_irq_q,
    output reg        cmp1_irq_q,
    output reg        cmp0_wake_q,
    output reg        cmp1_wake_q,
    output reg        cmp0_reset_src_q
);

    // ==========================================================
    // sticky flag next value
    function flag_next;
        input cur;
        input edge_seen;
        input wr_hit;
        input wr_val;
        begin
            // the edge wins over a clearing write
            flag_next = edge_seen | (wr_hit ? wr_val : cur);
        end
    endfunction

    // ==========================================================
    // state
    reg        cmp0_rise_flag;
    reg        cmp0_fall_flag;
    reg        cmp1_rise_flag;
    reg        cmp1_fall_flag;
    reg        cmp0_rise_irq_enable;
    reg        cmp0_fall_irq_enable;
    reg        cmp1_rise_irq_enable;
    reg        cmp1_fall_irq_enable;

    // named so that the two select fields can be cut out of the reset value
    localparam [7:0] sel_rst = `VCC_RST_SEL;

    wire       cmp0_result_bit;
    wire       cmp1_result_bit;
    wire       cmp0_rise_evt;
    wire       cmp0_fall_evt;
    wire       cmp1_rise_evt;
    wire       cmp1_fall_evt;

    wire wr_ctl0  = sfr_wr & (sfr_addr == `VCC_ADDR_CTL0);
    wire wr_ctl1  = sfr_wr & (sfr_addr == `VCC_ADDR_CTL1);
    wire wr_mode0 = sfr_wr & (sfr_addr == `VCC_ADDR_MODE0);
    wire wr_mode1 = sfr_wr & (sfr_addr == `VCC_ADDR_MODE1);
    wire wr_sel0  = sfr_wr & (sfr_addr == `VCC_ADDR_SEL0);
    wire wr_sel1  = sfr_wr & (sfr_addr == `VCC_ADDR_SEL1);

    // ==========================================================
    // two identical channels
    vcc_edge u_edge0 (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .ce        (ce),
        .enable    (cmp0_enable_bit),
        .analog_in (cmp0_analog_in),
        .result_q  (cmp0_result_bit),
        .rise_q    (cmp0_rise_evt),
        .fall_q    (cmp0_fall_evt)
    );

    vcc_edge u_edge1 (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .ce        (ce),
        .enable    (cmp1_enable_bit),
        .analog_in (cmp1_analog_in),
        .result_q  (cmp1_result_bit),
        .rise_q    (cmp1_rise_evt),
        .fall_q    (cmp1_fall_evt)
    );

    // ==========================================================
    // outputs toward pins
    // raw path has no flop so it keeps working with the clock stopped
    assign cmp0_raw_out     = cmp0_enable_bit & cmp0_analog_in;
    assign cmp1_raw_out     = cmp1_enable_bit & cmp1_analog_in;
    assign cmp0_latched_out = cmp0_result_bit;
    assign cmp1_latched_out = cmp1_result_bit;

    // ==========================================================
    // comparator 0 registers
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cmp0_enable_bit      <= 1'b0;
            cmp0_pos_hysteresis  <= `VCC_RST_HYST;
            cmp0_neg_hysteresis  <= `VCC_RST_HYST;
            cmp0_rise_flag       <= 1'b0;
            cmp0_fall_flag       <= 1'b0;
            cmp0_rise_irq_enable <= 1'b0;
            cmp0_fall_irq_enable <= 1'b0;
            cmp0_speed_mode      <= `VCC_RST_SPEED;
            cmp0_pos_input_sel   <= sel_rst[`VCC_SEL_POS_HI:`VCC_SEL_POS_LO];
            cmp0_neg_input_sel   <= sel_rst[`VCC_SEL_NEG_HI:`VCC_SEL_NEG_LO];
        end else if (ce) begin
            if (wr_ctl0) begin
                cmp0_enable_bit     <= sfr_wdata[`VCC_CTL_EN];
                cmp0_pos_hysteresis <= sfr_wdata[`VCC_CTL_HYP_HI:`VCC_CTL_HYP_LO];
                cmp0_neg_hysteresis <= sfr_wdata[`VCC_CTL_HYN_HI:`VCC_CTL_HYN_LO];
            end
            cmp0_rise_flag <= flag_next(cmp0_rise_flag, cmp0_rise_evt, wr_ctl0,
                                        sfr_wdata[`VCC_CTL_RISE]);
            cmp0_fall_flag <= flag_next(cmp0_fall_flag, cmp0_fall_evt, wr_ctl0,
                                        sfr_wdata[`VCC_CTL_FALL]);
            if (wr_mode0) begin
                cmp0_rise_irq_enable <= sfr_wdata[`VCC_MODE_RIE];
                cmp0_fall_irq_enable <= sfr_wdata[`VCC_MODE_FIE];
                cmp0_speed_mode      <= sfr_wdata[`VCC_MODE_MD_HI:`VCC_MODE_MD_LO];
            end
            if (wr_sel0) begin
                cmp0_neg_input_sel <= sfr_wdata[`VCC_SEL_NEG_HI:`VCC_SEL_NEG_LO];
                cmp0_pos_input_sel <= sfr_wdata[`VCC_SEL_POS_HI:`VCC_SEL_POS_LO];
            end
        end
    end

    // ==========================================================
    // comparator 1 registers
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cmp1_enable_bit      <= 1'b0;
            cmp1_pos_hysteresis  <= `VCC_RST_HYST;
            cmp1_neg_hysteresis  <= `VCC_RST_HYST;
            cmp1_rise_flag       <= 1'b0;
            cmp1_fall_flag       <= 1'b0;
            cmp1_rise_irq_enable <= 1'b0;
            cmp1_fall_irq_enable <= 1'b0;
            cmp1_speed_mode      <= `VCC_RST_SPEED;
            cmp1_pos_input_sel   <= sel_rst[`VCC_SEL_POS_HI:`VCC_SEL_POS_LO];
            cmp1_neg_input_sel   <= sel_rst[`VCC_SEL_NEG_HI:`VCC_SEL_NEG_LO];
        end else if (ce) begin
            if (wr_ctl1) begin
                cmp1_enable_bit     <= sfr_wdata[`VCC_CTL_EN];
                cmp1_pos_hysteresis <= sfr_wdata[`VCC_CTL_HYP_HI:`VCC_CTL_HYP_LO];
                cmp1_neg_hysteresis <= sfr_wdata[`VCC_CTL_HYN_HI:`VCC_CTL_HYN_LO];
            end
            cmp1_rise_flag <= flag_next(cmp1_rise_flag, cmp1_rise_evt, wr_ctl1,
                                        sfr_wdata[`VCC_CTL_RISE]);
            cmp1_fall_flag <= flag_next(cmp1_fall_flag, cmp1_fall_evt, wr_ctl1,
                                        sfr_wdata[`VCC_CTL_FALL]);
            if (wr_mode1) begin
                cmp1_rise_irq_enable <= sfr_wdata[`VCC_MODE_RIE];
                cmp1_fall_irq_enable <= sfr_wdata[`VCC_MODE_FIE];
                cmp1_speed_mode      <= sfr_wdata[`VCC_MODE_MD_HI:`VCC_MODE_MD_LO];
            end
            if (wr_sel1) begin
                cmp1_neg_input_sel <= sfr_wdata[`VCC_SEL_NEG_HI:`VCC_SEL_NEG_LO];
                cmp1_pos_input_sel <= sfr_wdata[`VCC_SEL_POS_HI:`VCC_SEL_POS_LO];
            end
        end
    end

    // ==========================================================
    // requests: interrupt, wake-up, reset source
    // the interrupt is a level that follows the flags, so software
    // drops it by clearing the flag
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cmp0_irq_q       <= 1'b0;
            cmp1_irq_q       <= 1'b0;
            cmp0_wake_q      <= 1'b0;
            cmp1_wake_q      <= 1'b0;
            cmp0_reset_src_q <= 1'b0;
        end else if (ce) begin
            cmp0_irq_q <= (cmp0_rise_flag & cmp0_rise_irq_enable) |
                          (cmp0_fall_flag & cmp0_fall_irq_enable);
            cmp1_irq_q <= (cmp1_rise_flag & cmp1_rise_irq_enable) |
                          (cmp1_fall_flag & cmp1_fall_irq_enable);
            cmp0_wake_q <= cmp0_enable_bit & ~cmp0_result_bit;
            cmp1_wake_q <= cmp1_enable_bit & ~cmp1_result_bit;
            // only comparator 0 offers a reset condition; the reset
            // controller decides whether to use it
            cmp0_reset_src_q <= cmp0_enable_bit & ~cmp0_result_bit;
        end
    end

    // ==========================================================
    // read path; reserved and unused bits read zero
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sfr_rdata_q <= 8'h00;
        end else if (ce && sfr_rd) begin
            case (sfr_addr)
                `VCC_ADDR_CTL0:
                    sfr_rdata_q <= {cmp0_enable_bit, cmp0_result_bit, cmp0_rise_flag,
                                    cmp0_fall_flag, cmp0_pos_hysteresis,
                                    cmp0_neg_hysteresis};
                `VCC_ADDR_CTL1:
                    sfr_rdata_q <= {cmp1_enable_bit, cmp1_result_bit, cmp1_rise_flag,
                                    cmp1_fall_flag, cmp1_pos_hysteresis,
                                    cmp1_neg_hysteresis};
                `VCC_ADDR_MODE0:
                    sfr_rdata_q <= {2'h0, cmp0_rise_irq_enable, cmp0_fall_irq_enable,
                                    2'h0, cmp0_speed_mode};
                `VCC_ADDR_MODE1:
                    sfr_rdata_q <= {2'h0, cmp1_rise_irq_enable, cmp1_fall_irq_enable,
                                    2'h0, cmp1_speed_mode};
                `VCC_ADDR_SEL0:
                    sfr_rdata_q <= {cmp0_neg_input_sel, cmp0_pos_input_sel};
                `VCC_ADDR_SEL1:
                    sfr_rdata_q <= {cmp1_neg_input_sel, cmp1_pos_input_sel};
                default:
                    sfr_rdata_q <= 8'h00;
            endcase
        end
    end

endmodule // vcc_top

// [testbench/vcc_monitor.sv]
`timescale 1ns/1ps
// ==========
// port checks for comparator 0 and the raw path, wake-up and control and mode writes of comparator 1
module vcc_monitor (
    // clock and reset
    input wire       clk_sys,
    input wire       rst,
    input wire       ce,
    // register port
    input wire [7:0] sfr_addr,
    input wire       sfr_wr,
    input wire [7:0] sfr_wdata,
    input wire       sfr_rd,
    input wire [7:0] sfr_rdata_q,
    // comparator side
    input wire       cmp0_analog_in,
    input wire       cmp1_analog_in,
    input wire       cmp0_enable_bit,
    input wire       cmp1_enable_bit,
    input wire [1:0] cmp0_pos_hysteresis,
    input wire [1:0] cmp0_neg_hysteresis,
    input wire [3:0] cmp0_pos_input_sel,
    input wire [3:0] cmp0_neg_input_sel,
    input wire [1:0] cmp0_speed_mode,
    input wire [1:0] cmp1_pos_hysteresis,
    input wire [1:0] cmp1_neg_hysteresis,
    input wire [1:0] cmp1_speed_mode,
    input wire       cmp0_raw_out,
    input wire       cmp1_raw_out,
    input wire       cmp0_latched_out,
    input wire       cmp1_latched_out,
    input wire       cmp0_wake_q,
    input wire       cmp1_wake_q,
    input wire       cmp0_reset_src_q
);
    reg [7:0] wd_q;
    always @(posedge clk_sys) begin
        wd_q <= sfr_wdata;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    raw0_gate_a: assert property (cmp0_raw_out == (cmp0_enable_bit & cmp0_analog_in))
        else $error("raw0 wrong");
    raw1_gate_a: assert property (cmp1_raw_out == (cmp1_enable_bit & cmp1_analog_in))
        else $error("raw1 wrong");
    ctl_write_a: assert property (sfr_wr && ce && sfr_addr == 8'h9b |=>
        {cmp0_enable_bit, cmp0_pos_hysteresis, cmp0_neg_hysteresis} == {wd_q[7], wd_q[3:0]})
        else $error("ctl0 write lost");
    sel_write_a: assert property (sfr_wr && ce && sfr_addr == 8'h9f |=>
        {cmp0_neg_input_sel, cmp0_pos_input_sel} == wd_q) else $error("sel0 write lost");
    mode_write_a: assert property (sfr_wr && ce && sfr_addr == 8'h9d |=>
        cmp0_speed_mode == wd_q[1:0]) else $error("mode0 write lost");
    mode_hold_a: assert property (!(sfr_wr && ce && sfr_addr == 8'h9d) |=>
        $stable(cmp0_speed_mode)) else $error("mode0 moved");
    rise_cause_a: assert property ($rose(cmp0_latched_out) |->
        $past(cmp0_analog_in, 3) && $past(cmp0_enable_bit, 1)) else $error("latched0 rose early");
    off_low_a: assert property (!cmp0_enable_bit [*4] |-> !cmp0_latched_out)
        else $error("latched0 high while off");
    wake_on_a: assert property ((cmp0_enable_bit && !cmp0_latched_out) [*2] |=> cmp0_wake_q)
        else $error("wake0 missing");
    wake1_on_a: assert property ((cmp1_enable_bit && !cmp1_latched_out) [*2] |=> cmp1_wake_q)
        else $error("wake1 missing");
    ctl1_write_a: assert property (sfr_wr && ce && sfr_addr == 8'h9a |=>
        {cmp1_enable_bit, cmp1_pos_hysteresis, cmp1_neg_hysteresis} == {wd_q[7], wd_q[3:0]})
        else $error("ctl1 write lost");
    mode1_write_a: assert property (sfr_wr && ce && sfr_addr == 8'h9c |=>
        cmp1_speed_mode == wd_q[1:0]) else $error("mode1 write lost");
    src_same_a: assert property (cmp0_reset_src_q == cmp0_wake_q)
        else $error("reset source differs");
    unmapped_rd_a: assert property (sfr_rd && ce && sfr_addr == 8'ha0 |=> sfr_rdata_q == 8'h00)
        else $error("unmapped read not zero");
endmodule // vcc_monitor

bind vcc_top vcc_monitor vcc_monitor_inst (.clk_sys(clk_sys), .rst(rst), .ce(ce), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata_q(sfr_rdata_q),
    .cmp0_analog_in(cmp0_analog_in), .cmp1_analog_in(cmp1_analog_in), .cmp0_enable_bit(cmp0_enable_bit),
    .cmp1_enable_bit(cmp1_enable_bit), .cmp0_pos_hysteresis(cmp0_pos_hysteresis),
    .cmp0_neg_hysteresis(cmp0_neg_hysteresis), .cmp0_pos_input_sel(cmp0_pos_input_sel),
    .cmp0_neg_input_sel(cmp0_neg_input_sel), .cmp0_speed_mode(cmp0_speed_mode), .cmp0_raw_out(cmp0_raw_out),
    .cmp1_raw_out(cmp1_raw_out), .cmp0_latched_out(cmp0_latched_out), .cmp0_wake_q(cmp0_wake_q),
    .cmp0_reset_src_q(cmp0_reset_src_q), .cmp1_pos_hysteresis(cmp1_pos_hysteresis),
    .cmp1_neg_hysteresis(cmp1_neg_hysteresis), .cmp1_speed_mode(cmp1_speed_mode),
    .cmp1_latched_out(cmp1_latched_out), .cmp1_wake_q(cmp1_wake_q));

// [testbench/vcc_pin_model.sv]
`timescale 1ns/1ps
// ==========
// port pin voltages in mV seen through both input muxes
module vcc_pin_model (
    // clock
    input  wire       clk_sys,
    // mux codes
    input  wire [3:0] pos0,
    input  wire [3:0] neg0,
    input  wire [3:0] pos1,
    input  wire [3:0] neg1,
    // decisions
    output wire       dec0,
    output wire       dec1
);
    integer mv [0:23];
    integer k;
    reg     flt_q = 1'b0;
    initial begin
        for (k = 0; k < 24; k = k + 1) mv[k] = 0;
    end
    // reserved codes reach no pin, so the decision floats and must not look settled
    always @(posedge clk_sys) begin
        flt_q <= ~flt_q;
    end
    assign dec0 = (pos0 > 4'hb || neg0 > 4'hb) ? flt_q : (mv[pos0 * 2] > mv[neg0 * 2 + 1]);
    assign dec1 = (pos1 > 4'hb || neg1 > 4'hb) ? flt_q : (mv[pos1 * 2] > mv[neg1 * 2 + 1]);
endmodule // vcc_pin_model

// [testbench/tb.sv]
`timescale 1ns/1ps
module tb;
    reg        clk_sys = 1'b0;
    reg        rst = 1'b1;
    reg        ce = 1'b1;
    reg  [7:0] sfr_addr = 8'h00;
    reg        sfr_wr = 1'b0;
    reg  [7:0] sfr_wdata = 8'h00;
    reg        sfr_rd = 1'b0;
    wire [7:0] rdata;
    wire [3:0] p0, n0, p1, n1;
    wire       a0, a1, raw0, raw1, lat0, lat1, irq0, irq1, wake0, wake1, rsrc0;
    integer    n_fail = 0;
    integer    num_checks = 0;
    integer    i;

    vcc_top vcc_top_inst (.clk_sys(clk_sys), .rst(rst), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata_q(rdata), .cmp0_analog_in(a0), .cmp1_analog_in(a1),
        .cmp0_enable_bit(), .cmp0_pos_hysteresis(), .cmp0_neg_hysteresis(), .cmp0_pos_input_sel(p0),
        .cmp0_neg_input_sel(n0), .cmp0_speed_mode(), .cmp1_enable_bit(), .cmp1_pos_hysteresis(),
        .cmp1_neg_hysteresis(), .cmp1_pos_input_sel(p1), .cmp1_neg_input_sel(n1), .cmp1_speed_mode(),
        .cmp0_raw_out(raw0), .cmp1_raw_out(raw1), .cmp0_latched_out(lat0), .cmp1_latched_out(lat1),
        .cmp0_irq_q(irq0), .cmp1_irq_q(irq1), .cmp0_wake_q(wake0), .cmp1_wake_q(wake1), .cmp0_reset_src_q(rsrc0));
    vcc_pin_model vcc_pin_model_inst (.clk_sys(clk_sys), .pos0(p0), .neg0(n0), .pos1(p1), .neg1(n1),
        .dec0(a0), .dec1(a1));

    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    // ==========
    // access and compare tasks
    task chk(input string nm, input [7:0] exp, input [7:0] got);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(posedge clk_sys);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge clk_sys);
        sfr_wr    <= 1'b0;
    endtask
    task rd(input [7:0] a, input [7:0] exp);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge clk_sys);
        sfr_rd   <= 1'b0;
        @(posedge clk_sys);
        #1 chk($sformatf("reg %h", a), exp, rdata);
    endtask
    task setv(input integer idx, input integer v);
        @(posedge clk_sys);
        vcc_pin_model_inst.mv[idx] <= v;
    endtask
    task waitc(input integer n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task give_verdict;
        if (n_fail == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ==========
    // tests
    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        for (i = 0; i < 6; i = i + 1) rd(8'h9a + i[7:0], (i < 2) ? 8'h00 : (i < 4) ? 8'h02 : 8'hff);
        rd(8'ha0, 8'h00);
        // a write while the clock enable is low must be dropped
        @(posedge clk_sys);
        ce <= 1'b0;
        wr(8'h9b, 8'h80);
        ce <= 1'b1;
        rd(8'h9b, 8'h00);
        for (i = 0; i < 4; i = i + 1) begin
            wr(8'h9b, {4'h0, i[1:0], i[1:0]});
            rd(8'h9b, {4'h0, i[1:0], i[1:0]});
            wr(8'h9c, {6'h3c, i[1:0]});
            rd(8'h9c, {6'h0c, i[1:0]});
        end
        wr(8'h9e, 8'hcd);
        rd(8'h9e, 8'hcd);
        // comparator 0: P0.0 against P0.1
        wr(8'h9f, 8'h00);
        setv(0, 100);
        setv(1, 50);
        wr(8'h9b, 8'h80);
        waitc(8);
        wr(8'h9b, 8'h80);
        rd(8'h9b, 8'hc0);
        chk("wake0", 8'h00, {7'h00, wake0});
        wr(8'h9d, 8'h10);
        setv(0, 10);
        waitc(8);
        rd(8'h9b, 8'h90);
        chk("wake0", 8'h01, {7'h00, wake0});
        chk("rsrc0", 8'h01, {7'h00, rsrc0});
        chk("irq0", 8'h01, {7'h00, irq0});
        chk("lat0", 8'h00, {7'h00, lat0});
        wr(8'h9b, 8'h80);
        setv(0, 100);
        waitc(2);
        // the clearing write lands on the rising-edge event, which must win
        wr(8'h9b, 8'h80);
        waitc(6);
        rd(8'h9b, 8'he0);
        chk("irq0", 8'h00, {7'h00, irq0});
        rd(8'h9d, 8'h10);
        // switching off with the decision high leaves one falling edge
        wr(8'h9b, 8'h00);
        waitc(6);
        rd(8'h9b, 8'h10);
        chk("raw0", 8'h00, {7'h00, raw0});
        chk("lat0", 8'h00, {7'h00, lat0});
        // comparator 1 at the last codes: P2.6 against P2.7
        wr(8'h9e, 8'hbb);
        wr(8'h9c, 8'h20);
        wr(8'h9a, 8'h80);
        waitc(8);
        chk("wake1", 8'h01, {7'h00, wake1});
        wr(8'h9a, 8'h80);
        setv(22, 9);
        waitc(8);
        rd(8'h9a, 8'he0);
        chk("irq1", 8'h01, {7'h00, irq1});
        chk("out1", 8'h03, {6'h00, raw1, lat1});
        chk("wake1", 8'h00, {7'h00, wake1});
        give_verdict;
    end

    initial begin
        repeat (3000) @(posedge clk_sys);
        n_fail = n_fail + 1;
        give_verdict;
    end
endmodule // tb
